// ---- src/tdc_pkg.sv ----
// Function
// - Touch declared after queue-count consecutive samples exceed threshold; 000/001 mean one.
// - Release confirmed by the same queue count of consecutive samples below threshold.
// - Each sensor channel keeps its own consecutive-sample counter.
// - Delta scaled by sensitivity code: 000 is 128x, halving to 1x at 111.
// - Base count presented shifted by code 0000..1000, 1x up to 256x.
// - Base scaling changes presentation only, never detection or sensitivity.
// - Timeout bit clear: no clock-low timeout and no idle reset.
// - Timeout bit set: abort after 30 ms clock low, reset after 150 us idle.
// - Deep sleep ignores idle reset; host must end every transaction with stop.
// - Slider select bit picks position or volumetric data; volumetric is host writable.
// - Noise filter bit clear excludes noisy samples from recalibration; set feeds all.
// - Low-frequency block bit clear blocks touch and retries calibration on noise.
// - Button hold recal bit set restarts recalibration after button hold limit.
// - Button repeat bit set repeats touch interrupts at the repeat rate.
// - Group hold recal bit set restarts recalibration after group hold limit.
// - Group repeat bit set repeats press-and-hold interrupt while pressed.
// - Scaled delta is 8-bit two's complement, saturating at 7f and ff.
// - Repeat interval is rate code plus one times 35 ms.
package tdc_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] TDC_ADDR_QUEUE = 8'h1e;
    localparam logic [7:0] TDC_ADDR_SENSE = 8'h1f;
    localparam logic [7:0] TDC_ADDR_CONF  = 8'h20;
    localparam logic [7:0] TDC_ADDR_VOL   = 8'h00;
    localparam logic [7:0] TDC_RST_QUEUE  = 8'h03;
    localparam logic [7:0] TDC_RST_SENSE  = 8'h2f;
    localparam logic [7:0] TDC_RST_CONF   = 8'h29;
    localparam logic [7:0] TDC_MASK_QUEUE = 8'h07;
    localparam logic [7:0] TDC_MASK_SENSE = 8'h7f;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int TDC_BIT_TIMEOUT = 7;
    localparam int TDC_BIT_SLIDER  = 6;
    localparam int TDC_BIT_DIGN    = 5;
    localparam int TDC_BIT_ANAN    = 4;
    localparam int TDC_BIT_BRECAL  = 3;
    localparam int TDC_BIT_BRPT    = 2;
    localparam int TDC_BIT_GRECAL  = 1;
    localparam int TDC_BIT_GRPT    = 0;
    localparam int TDC_CHANNELS    = 14;
    localparam logic [3:0] TDC_BASE_MAX = 4'h8;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int TDC_CLK_HZ        = 50_000_000;
    localparam int TDC_LOW_TMO_MS    = 30;
    localparam int TDC_IDLE_US       = 150;
    localparam int TDC_RPT_STEP_MS   = 35;
    localparam int TDC_LOW_TMO_CYC   = TDC_LOW_TMO_MS * (TDC_CLK_HZ / 1000);
    localparam int TDC_IDLE_CYC      = TDC_IDLE_US * (TDC_CLK_HZ / 1_000_000);
    localparam int TDC_RPT_STEP_CYC  = TDC_RPT_STEP_MS * (TDC_CLK_HZ / 1000);
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic timeout_enable;
        logic slider_data_select;
        logic noise_sample_filter_off;
        logic lowfreq_noise_block_off;
        logic button_hold_recal_enable;
        logic button_repeat_enable;
        logic group_hold_recal_enable;
        logic group_hold_repeat_enable;
    } tdc_conf_s;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tdc_reg_req_s;
    typedef enum logic [1:0] {
        TDC_BUS_RUN   = 2'b00,
        TDC_BUS_ABORT = 2'b01,
        TDC_BUS_IDLE  = 2'b10
    } tdc_bus_e;
endpackage : tdc_pkg

// ---- src/tdc_queue.sv ----
`timescale 1ns/10ps
module tdc_queue (
    // Clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       rstn_in,
    // Sample
    input  wire logic       sample_valid_in,
    input  wire logic       above_in,
    input  wire logic       block_in,
    input  wire logic [2:0] need_in,
    // State
    output logic            touched_out
);
    logic [2:0] run_q;
    logic       touched_q;
    logic       differs;
    logic       hit;

    assign differs = !block_in && (above_in != touched_q);
    assign hit     = differs && ({1'b0, run_q} + 4'h1 >= {1'b0, need_in});
    assign touched_out = touched_q;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            run_q <= 3'h0;
        end else if (sample_valid_in) begin
            if (!differs || hit) begin
                run_q <= 3'h0;
            end else begin
                run_q <= run_q + 3'h1;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            touched_q <= 1'b0;
        end else if (sample_valid_in && hit) begin
            touched_q <= ~touched_q;
        end
    end
endmodule : tdc_queue

// ---- src/tdc_top.sv ----
`timescale 1ns/10ps
module tdc_top (
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rstn_in,
    // Register port
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    output logic [7:0]       reg_rdata_out,
    output logic             reg_ack_out,
    // Sensing
    input  wire logic        sample_valid_in,
    input  wire logic [13:0] above_in,
    input  wire logic [13:0] lf_noise_in,
    input  wire logic [13:0] over_noise_in,
    input  wire logic [3:0]  delta_ch_in,
    input  wire logic [15:0] raw_delta_in,
    input  wire logic [15:0] raw_base_in,
    // Serial line watch
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    input  wire logic        deep_sleep_in,
    // Hold and slider
    input  wire logic        button_held_over_in,
    input  wire logic        group_held_over_in,
    input  wire logic        button_touch_ev_in,
    input  wire logic        group_hold_active_in,
    input  wire logic        group_hold_ev_in,
    input  wire logic [3:0]  repeat_rate_in,
    input  wire logic [6:0]  slider_pos_in,
    // Results
    output logic [13:0]      touched_out,
    output logic [7:0]       delta_out,
    output logic [7:0]       base_out,
    output logic [6:0]       slider_out,
    output logic [13:0]      recal_use_out,
    output logic [13:0]      cal_retry_out,
    output logic             recal_button_out,
    output logic             recal_group_out,
    output logic             irq_out,
    output logic             bus_abort_out,
    output logic             bus_reset_out
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0]          queue_q;
    logic [7:0]          sense_q;
    tdc_pkg::tdc_conf_s  conf_q;
    tdc_pkg::tdc_reg_req_s req;
    logic [6:0]          vol_q;
    logic [2:0]          need;

    function automatic logic [15:0] sat8(input logic signed [23:0] v);
        if (v > 24'sd127) begin
            sat8 = 16'h007f;
        end else if (v < 24'sd0) begin
            sat8 = 16'h00ff;
        end else begin
            sat8 = {8'h00, v[7:0]};
        end
    endfunction : sat8

    assign req  = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in, wdata: reg_wdata_in};
    assign need = (queue_q[2:0] == 3'h0) ? 3'h1 : queue_q[2:0];

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            queue_q <= tdc_pkg::TDC_RST_QUEUE;
            sense_q <= tdc_pkg::TDC_RST_SENSE;
            conf_q  <= tdc_pkg::TDC_RST_CONF;
        end else if (req.wr) begin
            if (req.addr == tdc_pkg::TDC_ADDR_QUEUE) begin
                queue_q <= req.wdata & tdc_pkg::TDC_MASK_QUEUE;
            end
            if (req.addr == tdc_pkg::TDC_ADDR_SENSE) begin
                sense_q <= req.wdata & tdc_pkg::TDC_MASK_SENSE;
            end
            if (req.addr == tdc_pkg::TDC_ADDR_CONF) begin
                conf_q <= req.wdata;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= 8'h00;
            reg_ack_out   <= 1'b0;
        end else begin
            reg_ack_out <= req.wr | req.rd;
            if (req.rd) begin
                unique case (req.addr)
                    tdc_pkg::TDC_ADDR_QUEUE: reg_rdata_out <= queue_q;
                    tdc_pkg::TDC_ADDR_SENSE: reg_rdata_out <= sense_q;
                    tdc_pkg::TDC_ADDR_CONF:  reg_rdata_out <= conf_q;
                    default:                 reg_rdata_out <= 8'h00;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Per-channel qualification
    // ----------------------------------------
    logic [13:0] touched;
    logic [13:0] block;
    // Noise blocking freezes the channel in its current state
    assign block = conf_q.lowfreq_noise_block_off ? 14'h0000 : lf_noise_in;

    for (genvar ch = 0; ch < tdc_pkg::TDC_CHANNELS; ch++) begin : g_ch
        tdc_queue u_queue (
            .sys_clk_in      (sys_clk_in),
            .rstn_in         (rstn_in),
            .sample_valid_in (sample_valid_in),
            .above_in        (above_in[ch]),
            .block_in        (block[ch]),
            .need_in         (need),
            .touched_out     (touched[ch])
        );
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            touched_out   <= 14'h0000;
            recal_use_out <= 14'h3fff;
            cal_retry_out <= 14'h0000;
        end else begin
            touched_out   <= touched;
            recal_use_out <= conf_q.noise_sample_filter_off ? 14'h3fff : ~over_noise_in;
            cal_retry_out <= block;
        end
    end

    // ----------------------------------------
    // Delta and base presentation
    // ----------------------------------------
    logic signed [23:0] delta_scaled;
    logic [15:0]        delta_sat;
    logic [3:0]         base_sh;
    logic [15:0]        base_scaled;

    // Base shift does not feed the queues: presentation only
    assign delta_scaled = ($signed({{8{raw_delta_in[15]}}, raw_delta_in}) <<< 7)
                          >>> sense_q[6:4];
    assign delta_sat    = sat8(delta_scaled);
    assign base_sh      = (sense_q[3:0] > tdc_pkg::TDC_BASE_MAX) ?
                          tdc_pkg::TDC_BASE_MAX : sense_q[3:0];
    assign base_scaled  = raw_base_in >> base_sh;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            delta_out <= 8'h00;
            base_out  <= 8'h00;
        end else begin
            if (sample_valid_in) begin
                delta_out <= delta_sat[7:0];
            end
            base_out <= (base_scaled > 16'h00ff) ? 8'hff : base_scaled[7:0];
        end
    end

    // ----------------------------------------
    // Slider data
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            vol_q <= 7'h00;
        end else if (conf_q.slider_data_select && req.wr &&
                     req.addr == tdc_pkg::TDC_ADDR_VOL) begin
            vol_q <= req.wdata[6:0];
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            slider_out <= 7'h00;
        end else begin
            slider_out <= conf_q.slider_data_select ? vol_q : slider_pos_in;
        end
    end

    // ----------------------------------------
    // Hold recalibration
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            recal_button_out <= 1'b0;
            recal_group_out  <= 1'b0;
        end else begin
            recal_button_out <= conf_q.button_hold_recal_enable & button_held_over_in;
            recal_group_out  <= conf_q.group_hold_recal_enable & group_held_over_in;
        end
    end

    // ----------------------------------------
    // Interrupt repeat
    // ----------------------------------------
    logic [31:0] rpt_cnt_q;
    logic [31:0] rpt_len;
    logic        rpt_on;
    logic        rpt_due;

    assign rpt_len = ({28'h0, repeat_rate_in} + 32'h1) * tdc_pkg::TDC_RPT_STEP_CYC;
    assign rpt_on  = (conf_q.button_repeat_enable && touched != 14'h0000) ||
                     (conf_q.group_hold_repeat_enable && group_hold_active_in);
    assign rpt_due = rpt_on && (rpt_cnt_q + 32'h1 >= rpt_len);

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rpt_cnt_q <= 32'h0;
        end else if (!rpt_on || rpt_due || button_touch_ev_in || group_hold_ev_in) begin
            rpt_cnt_q <= 32'h0;
        end else begin
            rpt_cnt_q <= rpt_cnt_q + 32'h1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= button_touch_ev_in || group_hold_ev_in || rpt_due;
        end
    end

    // ----------------------------------------
    // Serial line watch
    // ----------------------------------------
    tdc_pkg::tdc_bus_e bus_q;
    logic [31:0]       low_cnt_q;
    logic [31:0]       idle_cnt_q;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            low_cnt_q  <= 32'h0;
            idle_cnt_q <= 32'h0;
        end else begin
            low_cnt_q  <= (!scl_in && conf_q.timeout_enable) ? low_cnt_q + 32'h1 : 32'h0;
            idle_cnt_q <= (scl_in && sda_in && conf_q.timeout_enable) ?
                          idle_cnt_q + 32'h1 : 32'h0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus_q <= tdc_pkg::TDC_BUS_RUN;
        end else if (!conf_q.timeout_enable) begin
            bus_q <= tdc_pkg::TDC_BUS_RUN;
        end else begin
            unique case (bus_q)
                tdc_pkg::TDC_BUS_RUN: begin
                    if (low_cnt_q == 32'(tdc_pkg::TDC_LOW_TMO_CYC)) begin
                        bus_q <= tdc_pkg::TDC_BUS_ABORT;
                    end else if (idle_cnt_q == 32'(tdc_pkg::TDC_IDLE_CYC) &&
                                 !deep_sleep_in) begin
                        bus_q <= tdc_pkg::TDC_BUS_IDLE;
                    end
                end
                tdc_pkg::TDC_BUS_ABORT: bus_q <= tdc_pkg::TDC_BUS_RUN;
                tdc_pkg::TDC_BUS_IDLE:  bus_q <= tdc_pkg::TDC_BUS_RUN;
                default:                bus_q <= tdc_pkg::TDC_BUS_RUN;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus_abort_out <= 1'b0;
            bus_reset_out <= 1'b0;
        end else begin
            bus_abort_out <= (bus_q == tdc_pkg::TDC_BUS_ABORT);
            bus_reset_out <= (bus_q == tdc_pkg::TDC_BUS_IDLE);
        end
    end
endmodule : tdc_top

// ---- tb/tdc_properties.sv ----
`timescale 1ns/10ps
module tdc_properties (
    // Clock, reset, register port
    input wire logic        sys_clk_in,
    input wire logic        rstn_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_addr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic        reg_ack_out,
    // Sensing and lines
    input wire logic        sample_valid_in,
    input wire logic [13:0] over_noise_in,
    input wire logic [15:0] raw_delta_in,
    input wire logic [15:0] raw_base_in,
    input wire logic        scl_in,
    input wire logic        sda_in,
    input wire logic        deep_sleep_in,
    input wire logic        button_held_over_in,
    // Results
    input wire logic [7:0]  delta_out,
    input wire logic [7:0]  base_out,
    input wire logic [13:0] recal_use_out,
    input wire logic        recal_button_out,
    input wire logic        bus_abort_out,
    input wire logic        bus_reset_out
);
    localparam int IDLE_N = tdc_pkg::TDC_IDLE_CYC - 4;
    logic [7:0]  queue_q, sense_q, conf_q, rexp, dexp, bexp;
    logic [15:0] idle_q, bshift;
    logic [22:0] dscaled;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    // ----------------------------------------
    // Register shadow
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            queue_q <= tdc_pkg::TDC_RST_QUEUE;
            sense_q <= tdc_pkg::TDC_RST_SENSE;
            conf_q  <= tdc_pkg::TDC_RST_CONF;
        end else if (reg_wr_in) begin
            if (reg_addr_in == tdc_pkg::TDC_ADDR_QUEUE) begin
                queue_q <= reg_wdata_in & tdc_pkg::TDC_MASK_QUEUE;
            end
            if (reg_addr_in == tdc_pkg::TDC_ADDR_SENSE) begin
                sense_q <= reg_wdata_in & tdc_pkg::TDC_MASK_SENSE;
            end
            if (reg_addr_in == tdc_pkg::TDC_ADDR_CONF) begin
                conf_q <= reg_wdata_in;
            end
        end
    end
    // Saturates so one long idle gives one antecedent
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            idle_q <= 16'h0000;
        end else if (scl_in && sda_in && !deep_sleep_in) begin
            idle_q <= idle_q + 16'((idle_q != 16'hffff));
        end else begin
            idle_q <= 16'h0000;
        end
    end
    always_comb begin
        case (reg_addr_in)
            tdc_pkg::TDC_ADDR_QUEUE: rexp = queue_q;
            tdc_pkg::TDC_ADDR_SENSE: rexp = sense_q;
            tdc_pkg::TDC_ADDR_CONF:  rexp = conf_q;
            default:                 rexp = 8'h00;
        endcase
        dscaled = {raw_delta_in, 7'h00} >> sense_q[6:4];
        dexp = raw_delta_in[15] ? 8'hff : ((dscaled > 23'h7f) ? 8'h7f : dscaled[7:0]);
        bshift = raw_base_in >> ((sense_q[3:0] > 4'h8) ? 4'h8 : sense_q[3:0]);
        bexp = (bshift > 16'h00ff) ? 8'hff : bshift[7:0];
    end
    sequence s_idle_full;
        conf_q[7] && idle_q == IDLE_N;
    endsequence
    sequence s_reset_pulse;
        ##[0:8] bus_reset_out;
    endsequence
    AST_ACK: assert property ((reg_wr_in || reg_rd_in) |=> reg_ack_out)
        else $error("register ack missing");
    AST_READ: assert property (reg_rd_in |=> reg_rdata_out == $past(rexp))
        else $error("register read data wrong");
    AST_DELTA: assert property (sample_valid_in |=> delta_out == $past(dexp))
        else $error("scaled delta wrong");
    AST_BASE: assert property (sample_valid_in |=> base_out == $past(bexp))
        else $error("base presentation wrong");
    AST_RECAL_USE: assert property (sample_valid_in |=>
        recal_use_out == ($past(conf_q[5]) ? 14'h3fff : ~$past(over_noise_in)))
        else $error("recal sample use wrong");
    AST_IDLE_OFF: assert property (!conf_q[7] |-> !bus_reset_out && !bus_abort_out)
        else $error("bus watch active while disabled");
    AST_IDLE_RESET: assert property (s_idle_full |-> s_reset_pulse)
        else $error("idle reset pulse missing");
    AST_SLEEP: assert property (deep_sleep_in [*4] |-> !bus_reset_out)
        else $error("idle reset in deep sleep");
    AST_BTN_RECAL: assert property ((conf_q[3] && button_held_over_in) [*3]
        |-> recal_button_out) else $error("button hold recal missing");
endmodule : tdc_properties
bind tdc_top tdc_properties i_props (.sys_clk_in, .rstn_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
    .reg_wdata_in, .reg_rdata_out, .reg_ack_out, .sample_valid_in, .over_noise_in, .raw_delta_in,
    .raw_base_in, .scl_in, .sda_in, .deep_sleep_in, .button_held_over_in, .delta_out, .base_out,
    .recal_use_out, .recal_button_out, .bus_abort_out, .bus_reset_out);

// ---- tb/tdc_host_model.sv ----
`timescale 1ns/10ps
module tdc_host_model (
    // Clock
    input  wire logic       sys_clk_in,
    // Register port
    output logic            reg_wr_out,
    output logic            reg_rd_out,
    output logic [7:0]      reg_addr_out,
    output logic [7:0]      reg_wdata_out,
    input  wire logic       reg_ack_in,
    // Serial lines, idle high
    output logic            scl_out,
    output logic            sda_out
);
    initial begin
        {reg_wr_out, reg_rd_out, reg_addr_out, reg_wdata_out} = 18'h00000;
        {scl_out, sda_out} = 2'h3;
    end
    // One-cycle strobe; address and data inverted once released
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                          output logic ok);
        @(posedge sys_clk_in);
        {reg_wr_out, reg_rd_out, reg_addr_out, reg_wdata_out} <= {w, ~w, a, d};
        @(posedge sys_clk_in);
        {reg_wr_out, reg_rd_out, reg_addr_out, reg_wdata_out} <= {2'h0, ~a, ~d};
        @(posedge sys_clk_in);
        ok = reg_ack_in;
    endtask : access
    // Start then stop, so a sleeping slave recovers; access never calls it, only the idle test does
    task automatic stop_bit;
        @(posedge sys_clk_in);
        sda_out <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        scl_out <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        scl_out <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        sda_out <= 1'b1;
    endtask : stop_bit
endmodule : tdc_host_model

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
module testbench;
    logic        sys_clk_in, rstn_in, reg_wr_in, reg_rd_in, reg_ack_out, sample_valid_in;
    logic        scl_in, sda_in, deep_sleep_in, button_held_over_in, group_held_over_in;
    logic        button_touch_ev_in, group_hold_active_in, group_hold_ev_in, ok, rd_seen;
    logic        recal_button_out, recal_group_out, irq_out, bus_abort_out, bus_reset_out;
    logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out, delta_out, base_out;
    logic [13:0] above_in, lf_noise_in, over_noise_in, touched_out, recal_use_out;
    logic [13:0] cal_retry_out;
    logic [15:0] raw_delta_in, raw_base_in;
    logic [6:0]  slider_pos_in, slider_out;
    logic [3:0]  repeat_rate_in;
    logic [7:0]  exp_q[$];
    int          err_count, n_tests, irq_n, rst_n, seed = 32'h51d8;
    tdc_top i_dut (.sys_clk_in, .rstn_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
        .reg_rdata_out, .reg_ack_out, .sample_valid_in, .above_in, .lf_noise_in, .over_noise_in,
        .delta_ch_in(4'h0), .raw_delta_in, .raw_base_in, .scl_in, .sda_in, .deep_sleep_in,
        .button_held_over_in, .group_held_over_in, .button_touch_ev_in, .group_hold_active_in,
        .group_hold_ev_in, .repeat_rate_in, .slider_pos_in, .touched_out, .delta_out, .base_out,
        .slider_out, .recal_use_out, .cal_retry_out, .recal_button_out, .recal_group_out,
        .irq_out, .bus_abort_out, .bus_reset_out);
    tdc_host_model i_host (.sys_clk_in(sys_clk_in), .reg_wr_out(reg_wr_in),
        .reg_rd_out(reg_rd_in), .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in),
        .reg_ack_in(reg_ack_out), .scl_out(scl_in), .sda_out(sda_in));
    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic final_report;
        $display("mismatches %0d, comparisons %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.access(1'b1, a, d, ok);
        check(ok, 1'b1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_host.access(1'b0, a, 8'h00, ok);
        check(ok, 1'b1);
    endtask : rd
    task automatic sample(input logic [13:0] ab, input logic [13:0] lf);
        @(posedge sys_clk_in);
        {sample_valid_in, above_in, lf_noise_in} <= {1'b1, ab, lf};
        over_noise_in <= 14'($random(seed));
        {raw_delta_in, raw_base_in} <= 32'($random(seed));
        @(posedge sys_clk_in);
        sample_valid_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
    endtask : sample
    // ----------------------------------------
    // Read monitor and event counters
    // ----------------------------------------
    always @(posedge sys_clk_in) begin
        if (reg_ack_out === 1'b1 && rd_seen === 1'b1) begin
            check(reg_rdata_out, exp_q.pop_front());
        end
        rd_seen = reg_rd_in;
        irq_n += (irq_out === 1'b1);
        rst_n += (bus_reset_out === 1'b1);
    end
    initial begin
        repeat (50000) @(posedge sys_clk_in);
        err_count++;
        final_report();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int n, k;
        logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
        {rstn_in, sample_valid_in, above_in, lf_noise_in, over_noise_in} = 43'h0;
        {raw_delta_in, raw_base_in, deep_sleep_in, button_held_over_in} = 34'h0;
        {group_held_over_in, button_touch_ev_in, group_hold_active_in} = 3'h0;
        {group_hold_ev_in, repeat_rate_in, slider_pos_in, rd_seen} = 13'h0;
        repeat (2) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        rd(8'h1e, 8'h03);
        rd(8'h1f, 8'h2f);
        rd(8'h20, 8'h29);
        wr(8'h7f, 8'haa);
        rd(8'h7f, 8'h00);
        wr(8'h1e, 8'hff);
        rd(8'h1e, 8'h07);
        wr(8'h20, 8'h29);
        foreach (codes[i]) begin
            n = (codes[i] < 3'h2) ? 1 : int'(codes[i]);
            wr(8'h1e, {5'h00, codes[i]});
            for (k = 1; k < n; k++) sample(14'h0001, 14'h0004);
            if (n > 1) sample(14'h0002, 14'h0004);
            for (k = 1; k < n; k++) sample(14'h0005, 14'h0004);
            check(touched_out[0], 1'b0);
            sample(14'h0005, 14'h0004);
            check(touched_out, 14'h0001);
            check(cal_retry_out[2], 1'b1);
            for (k = 1; k < n; k++) sample(14'h0000, 14'h0000);
            check(touched_out[0], 1'b1);
            sample(14'h0000, 14'h0000);
            check(touched_out[0], 1'b0);
        end
        wr(8'h1e, 8'h01);
        wr(8'h20, 8'h39);
        sample(14'h0004, 14'h0004);
        check(touched_out[2], 1'b1);
        check(cal_retry_out[2], 1'b0);
        sample(14'h0000, 14'h0000);
        wr(8'h20, 8'h09);
        for (k = 0; k < 16; k++) begin
            wr(8'h1f, {1'b0, k[2:0], k[3:0]});
            rd(8'h1f, {1'b0, k[2:0], k[3:0]});
            repeat (3) sample(14'($random(seed)), 14'h0000);
            sample(14'h0000, 14'h0000);
        end
        wr(8'h20, 8'h29);
        irq_n = 0;
        button_touch_ev_in <= 1'b1;
        @(posedge sys_clk_in) button_touch_ev_in <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        group_hold_ev_in <= 1'b1;
        @(posedge sys_clk_in) group_hold_ev_in <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        check(irq_n, 2);
        {button_held_over_in, group_held_over_in} <= 2'h3;
        repeat (4) @(posedge sys_clk_in);
        check({recal_button_out, recal_group_out}, 2'h2);
        wr(8'h20, 8'h23);
        repeat (4) @(posedge sys_clk_in);
        check({recal_button_out, recal_group_out}, 2'h1);
        {button_held_over_in, group_held_over_in} <= 2'h0;
        slider_pos_in <= 7'($random(seed));
        wr(8'h20, 8'h29);
        check(slider_out, slider_pos_in);
        wr(8'h20, 8'h69);
        wr(8'h00, 8'h55);
        repeat (2) @(posedge sys_clk_in);
        check(slider_out, 7'h55);
        for (k = 0; k < 3; k++) begin
            wr(8'h20, (k == 0) ? 8'h29 : 8'ha9);
            deep_sleep_in <= (k == 2);
            i_host.stop_bit();
            rst_n = 0;
            repeat (tdc_pkg::TDC_IDLE_CYC + 500) @(posedge sys_clk_in);
            check(rst_n, (k == 1));
        end
        deep_sleep_in <= 1'b0;
        wr(8'h20, 8'h29);
        final_report();
    end
endmodule : testbench
